// file: core/rstko_pkg.sv
// constants, register map and state codes for the speed trim and keypad override block
package rstko_pkg;
	// timing
	localparam int CLK_HZ = 50_000_000;
	localparam int MIN_ON_TIME_MS = 50;
	localparam int MIN_ON_CYC = (CLK_HZ / 1000) * MIN_ON_TIME_MS;
	localparam int QUAL_W = 22;
	// widths
	localparam int FREQ_W = 16;
	localparam int ADDR_W = 8;
	// source selection codes
	localparam logic [1:0] SRC_OPERATOR = 2'h2;
	// register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_MAX_FREQ = 8'h04;
	localparam logic [7:0] REG_OP_FREQ = 8'h08;
	localparam logic [7:0] REG_ACCEL1 = 8'h0c;
	localparam logic [7:0] REG_DECEL1 = 8'h10;
	localparam logic [7:0] REG_ACCEL2 = 8'h14;
	localparam logic [7:0] REG_DECEL2 = 8'h18;
	localparam logic [7:0] REG_STATUS = 8'h1c;
	// control field positions
	localparam int CTRL_MEM_EN_BIT = 0;
	localparam int CTRL_SECOND_BIT = 1;
	localparam int CTRL_FSRC_LSB = 4;
	localparam int CTRL_RSRC_LSB = 8;
	localparam logic [31:0] CTRL_MASK = 32'h0000_0333;
	// status field positions
	localparam int STAT_RUN_BIT = 16;
	localparam int STAT_OVR_BIT = 17;
	localparam int STAT_STOP_BIT = 18;
	localparam int STAT_MOD_BIT = 19;
	localparam int STAT_UP_BIT = 20;
	localparam int STAT_DN_BIT = 21;
	// values after reset
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [15:0] MAX_FREQ_RST = 16'h1770;
	localparam logic [15:0] OP_FREQ_RST = 16'h0000;
	localparam logic [15:0] RATE_RST = 16'h0064;
	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// control sequence
	typedef enum logic [3:0] {
		ST_BOOT = 4'h1,
		ST_LOAD = 4'h2,
		ST_RUN = 4'h4,
		ST_STOP = 4'h8
	} rstko_state_e;
endpackage

// file: core/rstko_nvstore.sv
// retained store for the adjusted frequency, survives block reset
`timescale 1ns/100ps
module rstko_nvstore (
	// clock
	input wire logic clk,
	// write side
	input wire logic wr_en,
	input wire logic wr_valid,
	input wire logic [15:0] wr_data,
	// registered read side
	output logic rd_valid,
	output logic [15:0] rd_data
);
	// blank store at power on only, never touched by reset
	logic [16:0] mem_q = 17'h0_0000;
	logic [16:0] rd_q;

	// storage and registered read, write-through so a clear shows at once
	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem_q <= {wr_valid, wr_data};
		end
		rd_q <= wr_en ? {wr_valid, wr_data} : mem_q;
	end

	assign rd_valid = rd_q[16];
	assign rd_data = rd_q[15:0];
endmodule

// file: core/rstko_core.sv
// remote speed trim and keypad override core with axi4-lite registers
// What this block does
// - raise input ramps frequency up, release holds
// - lower input ramps frequency down, release holds
// - ramps use first or second motor rates
// - setting selects retaining adjusted frequency across power
// - memory off: restore pre-adjust frequency after power
// - clear input erases memory, restores set frequency
// - adjust only when source is operator code
// - adjust ignored while jog in use
// - adjusted frequency clamped between zero and maximum
// - adjustment starts from operator frequency setting
// - override takes frequency and run from operator
// - override released: configured sources apply again
// - override change while running stops motor first
// - operator run while running stops, then hands over
//
// The AXI4-Lite register port and the address map were chosen for this implementation.
`timescale 1ns/100ps
module rstko_core #(
	parameter int MIN_ON_CYCLES = rstko_pkg::MIN_ON_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// axi4-lite write channels
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read channels
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// terminal pins
	input wire logic raise_speed_input,
	input wire logic lower_speed_input,
	input wire logic adjust_memory_clear_input,
	input wire logic keypad_override_input,
	input wire logic jog_input,
	input wire logic terminal_run_input,
	// drive side
	input wire logic motor_running,
	input wire logic [15:0] ext_freq,
	input wire logic operator_run,
	input wire logic operator_stop,
	// command outputs
	output logic [15:0] freq_cmd,
	output logic run_cmd,
	output logic motor_stop,
	output logic freq_from_operator,
	output logic run_from_operator
);
	// byte-lane merge for register writes
	function automatic logic [31:0] merge_strb(input logic [31:0] old_v, input logic [31:0] new_v,
			input logic [3:0] strb);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[8*i +: 8] = new_v[8*i +: 8];
			end
		end
		return r;
	endfunction

	// limit a frequency to the maximum setting
	function automatic logic [15:0] clamp_max(input logic [15:0] v, input logic [15:0] m);
		return (v > m) ? m : v;
	endfunction

	// minimum on-time qualifier step
	function automatic logic [21:0] qual_next(input logic [21:0] cnt, input logic lvl);
		if (!lvl) begin
			return 22'h00_0000;
		end
		return (cnt >= 22'(MIN_ON_CYCLES)) ? cnt : cnt + 22'h00_0001;
	endfunction

	// pin synchronisers
	logic [5:0] sync1_q;
	logic [5:0] sync2_q;
	always_ff @(posedge clk) begin
		if (rst) begin
			sync1_q <= 6'h00;
			sync2_q <= 6'h00;
		end else begin
			sync1_q <= {terminal_run_input, jog_input, keypad_override_input,
				adjust_memory_clear_input, lower_speed_input, raise_speed_input};
			sync2_q <= sync1_q;
		end
	end
	wire raise_s = sync2_q[0];
	wire lower_s = sync2_q[1];
	wire clear_s = sync2_q[2];
	wire ovr_s = sync2_q[3];
	wire jog_s = sync2_q[4];
	wire term_run_s = sync2_q[5];

	// registers and state
	logic [31:0] ctrl_q;
	logic [15:0] max_q;
	logic [15:0] opset_q;
	logic [15:0] accel_time_first_q;
	logic [15:0] decel_time_first_q;
	logic [15:0] acc2_q;
	logic [15:0] dec2_q;
	logic [21:0] up_cnt_q;
	logic [21:0] dn_cnt_q;
	logic [15:0] rate_cnt_q;
	logic [15:0] adj_q;
	logic adj_mod_q;
	logic ovr_app_q;
	logic op_run_q;
	rstko_pkg::rstko_state_e state_q;
	rstko_pkg::rstko_state_e state_d;
	logic nv_rd_valid;
	logic [15:0] nv_rd_data;

	// axi write path
	logic aw_got_q;
	logic w_got_q;
	logic [7:0] wa_q;
	logic [31:0] wd_q;
	logic [3:0] ws_q;
	wire aw_hs = s_axi_awvalid & s_axi_awready;
	wire w_hs = s_axi_wvalid & s_axi_wready;
	wire wr_do = aw_got_q & w_got_q & ~s_axi_bvalid;
	wire aw_got_d = (aw_got_q | aw_hs) & ~wr_do;
	wire w_got_d = (w_got_q | w_hs) & ~wr_do;
	wire bvalid_d = wr_do | (s_axi_bvalid & ~s_axi_bready);
	wire wr_hit = (wa_q == rstko_pkg::REG_CTRL) | (wa_q == rstko_pkg::REG_MAX_FREQ) |
		(wa_q == rstko_pkg::REG_OP_FREQ) | (wa_q == rstko_pkg::REG_ACCEL1) |
		(wa_q == rstko_pkg::REG_DECEL1) | (wa_q == rstko_pkg::REG_ACCEL2) |
		(wa_q == rstko_pkg::REG_DECEL2) | (wa_q == rstko_pkg::REG_STATUS);
	wire [31:0] ctrl_w = merge_strb(ctrl_q, wd_q, ws_q) & rstko_pkg::CTRL_MASK;
	wire [31:0] max_w = merge_strb({16'h0000, max_q}, wd_q, ws_q);
	wire [31:0] opset_w = merge_strb({16'h0000, opset_q}, wd_q, ws_q);
	wire [31:0] accel_time_first_w = merge_strb({16'h0000, accel_time_first_q}, wd_q, ws_q);
	wire [31:0] decel_time_first_w = merge_strb({16'h0000, decel_time_first_q}, wd_q, ws_q);
	wire [31:0] acc2_w = merge_strb({16'h0000, acc2_q}, wd_q, ws_q);
	wire [31:0] dec2_w = merge_strb({16'h0000, dec2_q}, wd_q, ws_q);

	// write channel handshakes and response
	always_ff @(posedge clk) begin
		if (rst) begin
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= rstko_pkg::RESP_OKAY;
		end else begin
			aw_got_q <= aw_got_d;
			w_got_q <= w_got_d;
			s_axi_awready <= ~aw_got_d & ~bvalid_d;
			s_axi_wready <= ~w_got_d & ~bvalid_d;
			s_axi_bvalid <= bvalid_d;
			if (wr_do) begin
				s_axi_bresp <= wr_hit ? rstko_pkg::RESP_OKAY : rstko_pkg::RESP_SLVERR;
			end
		end
	end

	// captured write address and data
	always_ff @(posedge clk) begin
		if (rst) begin
			wa_q <= 8'h00;
			wd_q <= 32'h0000_0000;
			ws_q <= 4'h0;
		end else begin
			if (aw_hs) wa_q <= s_axi_awaddr;
			if (w_hs) wd_q <= s_axi_wdata;
			if (w_hs) ws_q <= s_axi_wstrb;
		end
	end

	// configuration registers
	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl_q <= rstko_pkg::CTRL_RST;
			max_q <= rstko_pkg::MAX_FREQ_RST;
			opset_q <= rstko_pkg::OP_FREQ_RST;
			accel_time_first_q <= rstko_pkg::RATE_RST;
			decel_time_first_q <= rstko_pkg::RATE_RST;
			acc2_q <= rstko_pkg::RATE_RST;
			dec2_q <= rstko_pkg::RATE_RST;
		end else if (wr_do) begin
			if (wa_q == rstko_pkg::REG_CTRL) ctrl_q <= ctrl_w;
			if (wa_q == rstko_pkg::REG_MAX_FREQ) max_q <= max_w[15:0];
			if (wa_q == rstko_pkg::REG_OP_FREQ) opset_q <= opset_w[15:0];
			if (wa_q == rstko_pkg::REG_ACCEL1) accel_time_first_q <= accel_time_first_w[15:0];
			if (wa_q == rstko_pkg::REG_DECEL1) decel_time_first_q <= decel_time_first_w[15:0];
			if (wa_q == rstko_pkg::REG_ACCEL2) acc2_q <= acc2_w[15:0];
			if (wa_q == rstko_pkg::REG_DECEL2) dec2_q <= dec2_w[15:0];
		end
	end

	// control fields
	wire mem_en = ctrl_q[rstko_pkg::CTRL_MEM_EN_BIT];
	wire second_sel = ctrl_q[rstko_pkg::CTRL_SECOND_BIT];
	wire [1:0] fsrc_cfg = ctrl_q[rstko_pkg::CTRL_FSRC_LSB +: 2];
	wire [1:0] rsrc_cfg = ctrl_q[rstko_pkg::CTRL_RSRC_LSB +: 2];

	// input qualification, partner must hold the contact long enough
	wire up_act = raise_s & (up_cnt_q >= 22'(MIN_ON_CYCLES));
	wire dn_act = lower_s & (dn_cnt_q >= 22'(MIN_ON_CYCLES));
	always_ff @(posedge clk) begin
		if (rst) begin
			up_cnt_q <= 22'h00_0000;
			dn_cnt_q <= 22'h00_0000;
		end else begin
			up_cnt_q <= qual_next(up_cnt_q, raise_s);
			dn_cnt_q <= qual_next(dn_cnt_q, lower_s);
		end
	end

	// effective sources, override forces operator
	wire [1:0] eff_fsrc = ovr_app_q ? rstko_pkg::SRC_OPERATOR : fsrc_cfg;
	wire fsrc_op = (eff_fsrc == rstko_pkg::SRC_OPERATOR);
	wire live = (state_q == rstko_pkg::ST_RUN) | (state_q == rstko_pkg::ST_STOP);
	wire ovr_app_d = (live & ~motor_running) ? ovr_s : ovr_app_q;
	wire [1:0] eff_rsrc_d = ovr_app_d ? rstko_pkg::SRC_OPERATOR : rsrc_cfg;

	// adjustment enables and ramp timing
	wire adj_allow = live & fsrc_op & ~jog_s;
	wire up_ok = adj_allow & up_act & ~dn_act;
	wire dn_ok = adj_allow & dn_act & ~up_act;
	wire [15:0] up_period = second_sel ? acc2_q : accel_time_first_q;
	wire [15:0] dn_period = second_sel ? dec2_q : decel_time_first_q;
	wire [15:0] period = up_ok ? up_period : dn_period;
	wire ramp_tick = (up_ok | dn_ok) & ({1'b0, rate_cnt_q} + 17'h0_0001 >= {1'b0, period});
	wire [15:0] adj_inc = (adj_q >= max_q) ? max_q : adj_q + 16'h0001;
	wire [15:0] adj_dec = (adj_q == 16'h0000) ? 16'h0000 : adj_q - 16'h0001;
	wire boot_load = (state_q == rstko_pkg::ST_LOAD);
	wire nv_ok = mem_en & nv_rd_valid;
	wire [15:0] boot_val = clamp_max(nv_ok ? nv_rd_data : opset_q, max_q);
	wire [15:0] opset_c = clamp_max(opset_q, max_q);

	// next adjusted frequency, by priority
	wire [15:0] adj_d = boot_load ? boot_val :
		clear_s ? opset_c :
		(adj_q > max_q) ? max_q :
		(up_ok & ramp_tick) ? adj_inc :
		(dn_ok & ramp_tick) ? adj_dec :
		~adj_mod_q ? boot_val :
		adj_q;
	wire adj_mod_d = boot_load ? nv_ok :
		clear_s ? 1'b0 :
		(((up_ok | dn_ok) & ramp_tick) | nv_ok) ? 1'b1 : adj_mod_q;

	// adjusted value, modified flag and ramp divider
	always_ff @(posedge clk) begin
		if (rst) begin
			adj_q <= 16'h0000;
			adj_mod_q <= 1'b0;
			rate_cnt_q <= 16'h0000;
		end else begin
			adj_q <= adj_d;
			adj_mod_q <= adj_mod_d;
			rate_cnt_q <= ((up_ok | dn_ok) & ~ramp_tick) ? rate_cnt_q + 16'h0001 : 16'h0000;
		end
	end

	// retained copy: written while enabled, erased by clear
	wire nv_wr_en = clear_s | (live & mem_en & adj_mod_q);
	rstko_nvstore u_nv (
		.clk(clk),
		.wr_en(nv_wr_en),
		.wr_valid(~clear_s),
		.wr_data(adj_q),
		.rd_valid(nv_rd_valid),
		.rd_data(nv_rd_data)
	);

	// override change and operator run takeover need a stop first
	wire ovr_change = (ovr_s != ovr_app_q);
	wire op_takeover = ovr_app_q & operator_run & motor_running;
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			rstko_pkg::ST_BOOT: state_d = rstko_pkg::ST_LOAD;
			rstko_pkg::ST_LOAD: state_d = rstko_pkg::ST_RUN;
			rstko_pkg::ST_RUN: begin
				if (motor_running & (ovr_change | op_takeover)) begin
					state_d = rstko_pkg::ST_STOP;
				end
			end
			rstko_pkg::ST_STOP: begin
				if (~motor_running) begin
					state_d = rstko_pkg::ST_RUN;
				end
			end
			default: state_d = rstko_pkg::ST_BOOT;
		endcase
	end

	// operator run latch, set wins over stop, cleared on forced stop
	wire op_run_d = (state_d == rstko_pkg::ST_STOP) ? 1'b0 :
		operator_run ? 1'b1 : operator_stop ? 1'b0 : op_run_q;
	wire run_op_d = (eff_rsrc_d == rstko_pkg::SRC_OPERATOR);
	wire run_d = (state_d == rstko_pkg::ST_RUN) & (run_op_d ? op_run_d : term_run_s);
	wire [15:0] freq_d = ~live ? 16'h0000 :
		fsrc_op ? adj_q : clamp_max(ext_freq, max_q);

	// control state and command outputs
	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= rstko_pkg::ST_BOOT;
			ovr_app_q <= 1'b0;
			op_run_q <= 1'b0;
			freq_cmd <= 16'h0000;
			run_cmd <= 1'b0;
			motor_stop <= 1'b0;
			freq_from_operator <= 1'b0;
			run_from_operator <= 1'b0;
		end else begin
			state_q <= state_d;
			ovr_app_q <= ovr_app_d;
			op_run_q <= op_run_d;
			freq_cmd <= freq_d;
			run_cmd <= run_d;
			motor_stop <= (state_d == rstko_pkg::ST_STOP);
			freq_from_operator <= fsrc_op;
			run_from_operator <= run_op_d;
		end
	end

	// axi read path
	wire ar_hs = s_axi_arvalid & s_axi_arready;
	wire rvalid_d = ar_hs | (s_axi_rvalid & ~s_axi_rready);
	wire [31:0] stat_w = {10'h000, dn_act, up_act, adj_mod_q,
		(state_q == rstko_pkg::ST_STOP), ovr_app_q, run_cmd, freq_cmd};
	wire rd_hit = (s_axi_araddr == rstko_pkg::REG_CTRL) |
		(s_axi_araddr == rstko_pkg::REG_MAX_FREQ) | (s_axi_araddr == rstko_pkg::REG_OP_FREQ) |
		(s_axi_araddr == rstko_pkg::REG_ACCEL1) | (s_axi_araddr == rstko_pkg::REG_DECEL1) |
		(s_axi_araddr == rstko_pkg::REG_ACCEL2) | (s_axi_araddr == rstko_pkg::REG_DECEL2) |
		(s_axi_araddr == rstko_pkg::REG_STATUS);
	wire [31:0] rd_word = (s_axi_araddr == rstko_pkg::REG_CTRL) ? ctrl_q :
		(s_axi_araddr == rstko_pkg::REG_MAX_FREQ) ? {16'h0000, max_q} :
		(s_axi_araddr == rstko_pkg::REG_OP_FREQ) ? {16'h0000, opset_q} :
		(s_axi_araddr == rstko_pkg::REG_ACCEL1) ? {16'h0000, accel_time_first_q} :
		(s_axi_araddr == rstko_pkg::REG_DECEL1) ? {16'h0000, decel_time_first_q} :
		(s_axi_araddr == rstko_pkg::REG_ACCEL2) ? {16'h0000, acc2_q} :
		(s_axi_araddr == rstko_pkg::REG_DECEL2) ? {16'h0000, dec2_q} :
		(s_axi_araddr == rstko_pkg::REG_STATUS) ? stat_w : 32'h0000_0000;

	// read channel handshake and data
	always_ff @(posedge clk) begin
		if (rst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= rstko_pkg::RESP_OKAY;
		end else begin
			s_axi_arready <= ~rvalid_d & ~ar_hs;
			s_axi_rvalid <= rvalid_d;
			if (ar_hs) begin
				s_axi_rdata <= rd_word;
				s_axi_rresp <= rd_hit ? rstko_pkg::RESP_OKAY : rstko_pkg::RESP_SLVERR;
			end
		end
	end

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	raise_step_a: assert property (
		up_ok && ramp_tick && !clear_s && adj_mod_q && adj_q < max_q
		|=> adj_q == $past(adj_q) + 16'h0001)
		else $error("raise did not step frequency up");
	lower_step_a: assert property (
		dn_ok && ramp_tick && !clear_s && adj_q > 16'h0000 && adj_q <= max_q
		|=> adj_q == $past(adj_q) - 16'h0001)
		else $error("lower did not step frequency down");
	ramp_rate_a: assert property (
		up_ok && adj_mod_q && !clear_s && adj_q <= max_q && !ramp_tick
		|=> adj_q == $past(adj_q))
		else $error("frequency moved between rate ticks");
	clear_restore_a: assert property (
		live && clear_s |=> adj_q == $past(opset_c) && !adj_mod_q)
		else $error("clear did not restore set frequency");
	src_gate_a: assert property (
		live && !fsrc_op && adj_mod_q && !clear_s && adj_q <= max_q
		|=> $stable(adj_q))
		else $error("adjusted while source not operator");
	jog_gate_a: assert property (
		live && jog_s && adj_mod_q && !clear_s && adj_q <= max_q |=> $stable(adj_q))
		else $error("adjusted while jog in use");
	max_clamp_a: assert property (
		live && adj_q > max_q && !clear_s |=> adj_q == $past(max_q))
		else $error("adjusted frequency above maximum");
	override_src_a: assert property (
		live && ovr_app_q |=> freq_from_operator)
		else $error("override did not select operator");
	override_stop_a: assert property (
		state_q == rstko_pkg::ST_RUN && motor_running && ovr_change
		|=> motor_stop && !run_cmd && ovr_app_q == $past(ovr_app_q))
		else $error("override applied without stopping");
	takeover_stop_a: assert property (
		state_q == rstko_pkg::ST_RUN && op_takeover |=> motor_stop ##0 !op_run_q)
		else $error("operator run did not stop motor first");
	both_hold_a: assert property (
		live && up_act && dn_act && adj_mod_q && !clear_s && adj_q <= max_q
		|=> $stable(adj_q))
		else $error("frequency moved with both inputs on");
endmodule

// file: sim/rstko_contacts.sv
// contact and drive model on the terminal side of the trim block
`timescale 1ns/100ps
module rstko_contacts #(
	parameter int MIN_ON = 4
) (
	// clock
	input wire logic clk,
	// drive side
	input wire logic run_cmd,
	output logic motor_running,
	// contacts
	output logic raise_speed_input,
	output logic lower_speed_input,
	output logic adjust_memory_clear_input,
	output logic keypad_override_input,
	output logic jog_input,
	output logic terminal_run_input
);
	logic [3:0] lag_q;
	// contacts open at power up
	initial begin
		lag_q = 4'h0;
		{raise_speed_input, lower_speed_input, adjust_memory_clear_input} = 3'h0;
		{keypad_override_input, jog_input, terminal_run_input} = 3'h0;
	end
	// motor speeds up and coasts down a few clocks behind the run command
	always @(posedge clk) begin
		lag_q <= {lag_q[2:0], run_cmd};
	end
	assign motor_running = lag_q[3];
	// close raise and/or lower, never shorter than the qualifier allows
	task automatic press(input logic up, input logic dn, input int n);
		int k;
		k = (n < MIN_ON + 4) ? MIN_ON + 4 : n;
		raise_speed_input <= up;
		lower_speed_input <= dn;
		repeat (k) @(posedge clk);
		raise_speed_input <= 1'b0;
		lower_speed_input <= 1'b0;
	endtask
	// level contacts
	task automatic set_pins(input logic clr, input logic ovr, input logic jog, input logic trun);
		adjust_memory_clear_input <= clr;
		keypad_override_input <= ovr;
		jog_input <= jog;
		terminal_run_input <= trun;
	endtask
endmodule

// file: sim/rstko_core_tb.sv
// self-checking bench for the speed trim and keypad override core
`timescale 1ns/100ps
module rstko_core_tb;
	localparam int MINON = 4;
	localparam logic [1:0] OK = rstko_pkg::RESP_OKAY;
	// clock, reset and bus
	logic clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	// pins and drive side
	logic raise_i, lower_i, clear_i, ovr_i, jog_i, trun_i;
	logic motor_running, operator_run, operator_stop, run_cmd, motor_stop;
	logic freq_from_operator, run_from_operator;
	logic [15:0] ext_freq, freq_cmd, v;
	int fails, n_tests, alo, ahi;

	rstko_core #(.MIN_ON_CYCLES(MINON)) u_rstko_core (
		.clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.raise_speed_input(raise_i), .lower_speed_input(lower_i),
		.adjust_memory_clear_input(clear_i), .keypad_override_input(ovr_i),
		.jog_input(jog_i), .terminal_run_input(trun_i), .motor_running(motor_running),
		.ext_freq(ext_freq), .operator_run(operator_run), .operator_stop(operator_stop),
		.freq_cmd(freq_cmd), .run_cmd(run_cmd), .motor_stop(motor_stop),
		.freq_from_operator(freq_from_operator), .run_from_operator(run_from_operator)
	);
	rstko_contacts #(.MIN_ON(MINON)) u_rstko_contacts (
		.clk(clk), .run_cmd(run_cmd), .motor_running(motor_running),
		.raise_speed_input(raise_i), .lower_speed_input(lower_i),
		.adjust_memory_clear_input(clear_i), .keypad_override_input(ovr_i),
		.jog_input(jog_i), .terminal_run_input(trun_i)
	);

	// compare and count
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic win(input string nm, input logic [15:0] seen, input int lo, input int hi);
		chk(nm, 32'(seen >= 16'(lo) && seen <= 16'(hi)), 32'h1);
	endtask
	// bus write, address and data offered together
	task automatic wrc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		chk("bresp", 32'(bresp), 32'(er));
		bready <= 1'b0;
		@(posedge clk);
	endtask
	// bus read
	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		chk("rdata", rdata, e);
		chk("rresp", 32'(rresp), 32'(er));
		rready <= 1'b0;
		@(posedge clk);
	endtask
	// keypad run or stop key
	task automatic key(input logic stop);
		operator_run <= !stop;
		operator_stop <= stop;
		@(posedge clk);
		operator_run <= 1'b0;
		operator_stop <= 1'b0;
		@(posedge clk);
	endtask
	function automatic logic pick(input int s);
		return s == 0 ? motor_stop : (s == 1 ? motor_running : run_cmd);
	endfunction
	// bounded wait for stop flag, motor or run command
	task automatic wait_for(input int s, input logic want);
		int t;
		t = 0;
		while (pick(s) !== want && t < 200) begin
			@(posedge clk);
			t++;
		end
		chk("wait", 32'(pick(s)), 32'(want));
	endtask
	// ramp the model's bounds by one press of k clocks at per clocks a step
	task automatic ramp(input logic up, input int k, input int per);
		int lo;
		int hi;
		lo = (k - MINON - 4) / per - 2;
		hi = k / per + 1;
		u_rstko_contacts.press(up, !up, k);
		repeat (6) @(posedge clk);
		alo = up ? alo + lo : alo - hi;
		ahi = up ? ahi + hi : ahi - lo;
	endtask
	task automatic close_out;
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// watchdog
	initial begin
		repeat (40000) @(posedge clk);
		fails++;
		close_out();
	end
	// main sequence
	initial begin
		{rst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
		{operator_run, operator_stop, awaddr, araddr} = 18'h0;
		{wdata, ext_freq} = 48'h0;
		wstrb = 4'hf;
		fails = 0;
		n_tests = 0;
		void'($urandom(23258));
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		// values after reset and an unmapped place
		rdc(rstko_pkg::REG_CTRL, rstko_pkg::CTRL_RST, OK);
		rdc(rstko_pkg::REG_MAX_FREQ, 32'(rstko_pkg::MAX_FREQ_RST), OK);
		rdc(rstko_pkg::REG_OP_FREQ, 32'(rstko_pkg::OP_FREQ_RST), OK);
		for (int a = 12; a <= 24; a += 4) rdc(8'(a), 32'(rstko_pkg::RATE_RST), OK);
		rdc(8'h20, 32'h0, rstko_pkg::RESP_SLVERR);
		wrc(8'h20, 32'h5, rstko_pkg::RESP_SLVERR);
		// operator source, max 100, set 50, rates 2/3 and 1/1
		wrc(rstko_pkg::REG_MAX_FREQ, 32'h64, OK);
		wrc(rstko_pkg::REG_OP_FREQ, 32'h32, OK);
		for (int a = 12; a <= 24; a += 4) wrc(8'(a), a < 20 ? 32'(a / 4 - 1) : 32'h1, OK);
		wrc(rstko_pkg::REG_CTRL, 32'h20, OK);
		repeat (4) @(posedge clk);
		chk("start", 32'(freq_cmd), 32'h32);
		alo = 50;
		ahi = 50;
		ramp(1'b1, 30 + int'($urandom % 20), 2);
		win("raise", freq_cmd, alo, ahi);
		v = freq_cmd;
		repeat (30) @(posedge clk);
		chk("held", 32'(freq_cmd), 32'(v));
		ramp(1'b0, 40, 3);
		win("lower", freq_cmd, alo, ahi);
		// both contacts, jog, and a non-operator source leave it alone
		for (int i = 0; i < 3; i++) begin
			v = freq_cmd;
			ext_freq <= 16'($urandom_range(150, 20));
			if (i == 1) u_rstko_contacts.set_pins(1'b0, 1'b0, 1'b1, 1'b0);
			if (i == 2) wrc(rstko_pkg::REG_CTRL, 32'h0, OK);
			u_rstko_contacts.press(1'b1, i == 0, 40);
			repeat (6) @(posedge clk);
			if (i == 2) chk("ext", 32'(freq_cmd), 32'(ext_freq > 16'h64 ? 16'h64 : ext_freq));
			if (i == 2) wrc(rstko_pkg::REG_CTRL, 32'h20, OK);
			u_rstko_contacts.set_pins(1'b0, 1'b0, 1'b0, 1'b0);
			repeat (6) @(posedge clk);
			chk("no ramp", 32'(freq_cmd), 32'(v));
		end
		// clamps at both ends, second motor rate on the way down
		u_rstko_contacts.press(1'b1, 1'b0, 300);
		repeat (6) @(posedge clk);
		chk("top", 32'(freq_cmd), 32'h64);
		wrc(rstko_pkg::REG_CTRL, 32'h22, OK);
		alo = 100;
		ahi = 100;
		ramp(1'b0, 30, 1);
		win("second", freq_cmd, alo, ahi);
		u_rstko_contacts.press(1'b0, 1'b1, 300);
		repeat (6) @(posedge clk);
		chk("bottom", 32'(freq_cmd), 32'h0);
		// clear returns to the set value, release changes nothing
		u_rstko_contacts.set_pins(1'b1, 1'b0, 1'b0, 1'b0);
		repeat (8) @(posedge clk);
		chk("clear", 32'(freq_cmd), 32'h32);
		u_rstko_contacts.set_pins(1'b0, 1'b0, 1'b0, 1'b0);
		repeat (8) @(posedge clk);
		chk("unclear", 32'(freq_cmd), 32'h32);
		// power loss: kept with memory on, forgotten with memory off
		for (int m = 1; m >= 0; m--) begin
			wrc(rstko_pkg::REG_CTRL, 32'h22 | 32'(m), OK);
			u_rstko_contacts.press(1'b1, 1'b0, 30);
			repeat (6) @(posedge clk);
			v = freq_cmd;
			rst <= 1'b1;
			repeat (3) @(posedge clk);
			rst <= 1'b0;
			@(posedge clk);
			if (m == 1) wrc(rstko_pkg::REG_CTRL, 32'h21, OK);
			if (m == 1) repeat (4) @(posedge clk);
			if (m == 1) chk("kept", 32'(freq_cmd), 32'(v));
		end
		wrc(rstko_pkg::REG_OP_FREQ, 32'h4d, OK);
		wrc(rstko_pkg::REG_CTRL, 32'h20, OK);
		repeat (4) @(posedge clk);
		chk("restore", 32'(freq_cmd), 32'h4d);
		// terminal run, then keypad override while running
		wrc(rstko_pkg::REG_CTRL, 32'h0, OK);
		u_rstko_contacts.set_pins(1'b0, 1'b0, 1'b0, 1'b1);
		wait_for(2, 1'b1);
		wait_for(1, 1'b1);
		chk("ext run", {run_from_operator, freq_cmd}, {1'b0, ext_freq});
		u_rstko_contacts.set_pins(1'b0, 1'b1, 1'b0, 1'b1);
		wait_for(0, 1'b1);
		chk("stopping", 32'(run_cmd), 32'h0);
		wait_for(0, 1'b0);
		repeat (2) @(posedge clk);
		chk("keypad", {freq_from_operator, run_from_operator, run_cmd, freq_cmd},
			{3'b110, 16'h4d});
		key(1'b0);
		wait_for(2, 1'b1);
		wait_for(1, 1'b1);
		key(1'b1);
		wait_for(2, 1'b0);
		wait_for(1, 1'b0);
		key(1'b0);
		wait_for(1, 1'b1);
		key(1'b0);
		wait_for(0, 1'b1);
		wait_for(0, 1'b0);
		chk("handed", {run_from_operator, run_cmd}, 2'b10);
		key(1'b0);
		wait_for(1, 1'b1);
		u_rstko_contacts.set_pins(1'b0, 1'b0, 1'b0, 1'b1);
		wait_for(0, 1'b1);
		wait_for(0, 1'b0);
		repeat (2) @(posedge clk);
		chk("back", {freq_from_operator, freq_cmd}, {1'b0, ext_freq});
		wait_for(2, 1'b1);
		close_out();
	end
endmodule
